// [bench/pstdbg_bench.sv]
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Self-checking bench for the status and debug pin block.
// -----------------------------------------------------------------
module pstdbg_bench;
  import pstdbg_pkg::*;
  logic mclk = 1'b0, arst_n = 1'b1, evtValid = 1'b0, evtReady;
  pstdbg_evt_t evtKind = EV_INSN;
  logic [1:0] evtBytes = 2'h0;
  logic [31:0] evtData = 32'h0;
  logic coreStopped = 1'b0, coreHalted = 1'b0, debugModeSel = 1'b0, modeSelectIn = 1'b0;
  logic [3:0] statusCode, debugDataBus;
  logic statusCodeOe, statusClockOut, serialDataOut, serialDataOutOe, breakpointRequest;
  logic dbgRxValid, debugSerialClock, serialDataIn;
  logic testClock = 1'b0; // Scan test clock, walked by hand.
  logic [16:0] dbgRxData, rxWord = 17'h0, dbgTxData = 17'h0;
  int fails = 0, comparisons = 0, rxCount = 0, bpCount = 0;

  // Clock.
  always #50 mclk = ~mclk;

  // Block under test.
  pstdbg_top DUT (.mclk(mclk), .arst_n(arst_n), .evtValid(evtValid), .evtReady(evtReady),
    .evtKind(evtKind), .evtBytes(evtBytes), .evtData(evtData), .coreStopped(coreStopped),
    .coreHalted(coreHalted), .statusCode(statusCode), .statusCodeOe(statusCodeOe),
    .statusClockOut(statusClockOut), .debugDataBus(debugDataBus), .debugModeSel(debugModeSel),
    .testClock(testClock), .debugSerialClock(debugSerialClock), .modeSelectIn(modeSelectIn),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .serialDataOutOe(serialDataOutOe), .breakpointRequest(breakpointRequest),
    .dbgRxValid(dbgRxValid), .dbgRxData(dbgRxData), .dbgTxData(dbgTxData));

  pstdbg_tool TOOL (.mclk(mclk), .statusCode(statusCode), .statusClockOut(statusClockOut),
    .debugDataBus(debugDataBus), .serialDataOut(serialDataOut),
    .debugSerialClock(debugSerialClock), .serialDataIn(serialDataIn));

  // Count received words and breakpoint pulses.
  always @(posedge mclk) begin
    if (dbgRxValid === 1'b1) begin
      rxCount <= rxCount + 1;
      rxWord <= dbgRxData;
    end
    if (breakpointRequest === 1'b1) begin
      bpCount <= bpCount + 1;
    end
  end

  // -----------------------------------------------------------------
  // Shared tasks.
  // -----------------------------------------------------------------
  task automatic close_out;
    $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpVal

  // Offer one event and return at the edge that takes it; valid is left high.
  task automatic push(input pstdbg_evt_t k, input logic [1:0] b, input logic [31:0] d);
    int n = 0;
    evtValid <= 1'b1;
    evtKind <= k;
    evtBytes <= b;
    evtData <= d;
    @(negedge mclk);
    while (evtReady !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n == 200) begin
      fails++;
      close_out();
    end
    @(posedge mclk);
  endtask : push

  // Next captured period, waiting a bounded time.
  task automatic pop(output logic [7:0] e);
    int n = 0;
    while (TOOL.capQ.size() == 0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n == 200) begin
      fails++;
      close_out();
    end
    e = TOOL.capQ.pop_front();
  endtask : pop

  // Skip continue periods and one stale code, then compare the next code.
  task automatic seek(input logic [3:0] want, input logic [3:0] skip = 4'h0);
    logic [7:0] e = 8'h00;
    for (int i = 0; i < 40 && (e[7:4] == 4'h0 || e[7:4] == skip); i++) pop(e);
    cmpVal(e[7:4], want);
  endtask : seek

  // -----------------------------------------------------------------
  // Scenarios.
  // -----------------------------------------------------------------
  // Back-to-back instruction-type events, each with its own code.
  task automatic t_codes;
    pstdbg_evt_t k[5] = '{EV_INSN, EV_USER, EV_MARK, EV_BRANCH, EV_RETURN};
    logic [3:0] c[5] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h7};
    TOOL.capQ.delete();
    foreach (k[i]) push(k[i], 2'h0, 32'h0);
    evtValid <= 1'b0;
    foreach (c[i]) seek(c[i]);
    $display("test codes done");
  endtask : t_codes

  // Exception codes stand for more than one period.
  task automatic t_exc;
    logic [7:0] e;
    push(EV_EXC, 2'h0, 32'h0);
    push(EV_EMU, 2'h0, 32'h0);
    evtValid <= 1'b0;
    seek(4'hc);
    pop(e);
    cmpVal(e[7:4], 4'hc);
    seek(4'hd);
    pop(e);
    cmpVal(e[7:4], 4'hd);
    $display("test exceptions done");
  endtask : t_exc

  // Every transfer length: start code, then low nibble first under code 0000.
  task automatic t_data;
    logic [7:0] e;
    logic [31:0] d = 32'h8765_4321;
    for (int b = 0; b < 4; b++) begin
      push(EV_DATA, b[1:0], d);
      evtValid <= 1'b0;
      seek(4'h8 + b[3:0]);
      for (int i = 0; i < 2 * (b + 1); i++) begin
        pop(e);
        cmpVal(e, {4'h0, d[4 * i +: 4]});
      end
    end
    $display("test data done");
  endtask : t_data

  // Halt stalls the buffer until it refuses; stop then holds; drain afterwards.
  task automatic t_halt;
    coreHalted <= 1'b1;
    coreStopped <= 1'b1;
    repeat (6) @(posedge mclk);
    TOOL.capQ.delete();
    push(EV_INSN, 2'h0, 32'h0);
    push(EV_BRANCH, 2'h0, 32'h0);
    evtKind <= EV_MARK;
    repeat (8) @(negedge mclk) cmpVal(evtReady, 1'b0);
    @(posedge mclk);
    evtValid <= 1'b0;
    seek(4'hf);
    coreHalted <= 1'b0;
    seek(4'he, 4'hf);
    coreStopped <= 1'b0;
    seek(4'h1, 4'he);
    seek(4'h5);
    $display("test halt done");
  endtask : t_halt

  // Debug serial words in both directions, then a breakpoint request.
  task automatic t_serial;
    debugModeSel <= 1'b1;
    dbgTxData <= 17'h1a5c3;
    repeat (5) @(posedge mclk);
    TOOL.frame(17'h0b3c5);
    repeat (10) @(posedge mclk);
    cmpVal(rxCount, 1);
    cmpVal(rxWord, 17'h0b3c5);
    cmpVal(serialDataOutOe, 1'b1);
    TOOL.frame(17'h00000);
    cmpVal(TOOL.readWord, 17'h1a5c3);
    modeSelectIn <= 1'b1;
    repeat (10) @(posedge mclk);
    cmpVal(bpCount, 1);
    modeSelectIn <= 1'b0;
    $display("test serial done");
  endtask : t_serial

  // Scan use: release scan reset, walk to data shift, see the identity low bit.
  task automatic t_scan;
    logic [3:0] tms = 4'b0100;
    debugModeSel <= 1'b0;
    TOOL.debugSerialClock <= 1'b1;
    foreach (tms[i]) begin
      modeSelectIn <= tms[i];
      repeat (4) @(posedge mclk);
      testClock <= 1'b1;
      repeat (4) @(posedge mclk);
      testClock <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    cmpVal({serialDataOutOe, serialDataOut}, 2'h3);
    $display("test scan done");
  endtask : t_scan

  // Main sequence.
  initial begin
    arst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    cmpVal(statusCodeOe, 1'b0);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    cmpVal(statusCodeOe, 1'b1);
    t_codes();
    t_exc();
    t_data();
    t_halt();
    t_serial();
    t_scan();
    cmpVal(TOOL.badCodes, 0);
    close_out();
  end
endmodule : pstdbg_bench

// [bench/pstdbg_tool.sv]
`timescale 1ns/1ps

// -----------------------------------------------------------------
// Debug tool model: status capture probe and debug serial channel.
// -----------------------------------------------------------------
module pstdbg_tool (
  input wire logic mclk, // Block clock, used to sample the status pins.
  input wire logic [3:0] statusCode, // Status pins.
  input wire logic statusClockOut, // Status clock pin.
  input wire logic [3:0] debugDataBus, // Data nibble pins.
  input wire logic serialDataOut, // Shared serial output pin.
  output logic debugSerialClock, // Debug clock, still between frames.
  output logic serialDataIn // Shared serial input pin.
);
  logic lastClk = 1'b0; // Previous status clock level.
  logic [7:0] capQ[$]; // One code and nibble per status period.
  logic [16:0] readWord = 17'h00000; // Bits returned in the last frame.
  int badCodes = 0; // Captures of a reserved code.

  // Idle link: clock low, data low.
  initial begin
    debugSerialClock = 1'b0;
    serialDataIn = 1'b0;
  end

  // Capture once per period on the rising status clock; repeats are kept.
  always @(posedge mclk) begin
    if (statusClockOut === 1'b1 && lastClk === 1'b0) begin
      capQ.push_back({statusCode, debugDataBus});
      // A reserved code is invalid when observed.
      if (statusCode == 4'h2 || statusCode == 4'h6) begin
        badCodes++;
      end
    end
    lastClk <= statusClockOut;
  end

  // Send one word MSB first, collecting the device's bits before each fall.
  task automatic frame(input logic [16:0] word);
    #17;
    for (int i = 16; i >= 0; i--) begin
      serialDataIn = word[i];
      #400 debugSerialClock = 1'b1;
      #400 readWord = {readWord[15:0], serialDataOut};
      debugSerialClock = 1'b0;
    end
    // The released line must not keep the last bit, so it shows the inverse.
    serialDataIn = ~word[0];
  endtask : frame
endmodule : pstdbg_tool

// [shared/pstdbg_map.svh]
// Functional notes
// R1 - Four status pins, high impedance during reset.
// R2 - Codes 0000 continue, 0001 instruction, 0011 user.
// R3 - Code 0100 for marker or debug-write instruction.
// R4 - Code 0101 for taken branch or sync.
// R5 - Code 0111 for exception return instruction.
// R6 - Codes 1000 to 1011 start 1-4 byte transfers.
// R7 - Code 1100 exception, 1101 emulator entry exception.
// R8 - Code 1110 stopped, 1111 halted.
// R9 - Exception, emulator, stop, halt codes last several cycles.
// R10 - Shared clock pin: scan reset or debug clock.
// R11 - Shared pin: scan mode select or breakpoint.
// R12 - Shared serial input feeds scan or debug logic.
// R13 - Shared serial output from scan or debug logic.
// R14 - Boundary-scan port follows 1149.1A, own test clock.
// R15 - Reserved codes 0010 and 0110 never driven.
// R16 - Status changes with status clock output edge.
`ifndef PSTDBG_MAP_SVH
`define PSTDBG_MAP_SVH

// -----------------------------------------------------------------
// Status codes.
// -----------------------------------------------------------------
`define PSTDBG_PST_CONTINUE 4'h0
`define PSTDBG_PST_INSN 4'h1
`define PSTDBG_PST_USER 4'h3
`define PSTDBG_PST_MARK 4'h4
`define PSTDBG_PST_BRANCH 4'h5
`define PSTDBG_PST_RETURN 4'h7
`define PSTDBG_PST_DATA 2'b10
`define PSTDBG_PST_EXC 4'hc
`define PSTDBG_PST_EMU 4'hd
`define PSTDBG_PST_STOP 4'he
`define PSTDBG_PST_HALT 4'hf

// -----------------------------------------------------------------
// Timing and widths.
// -----------------------------------------------------------------
`define PSTDBG_EXC_TICKS 2'd2
`define PSTDBG_EVT_W 37
`define PSTDBG_DBG_W 17
`define PSTDBG_DBG_LAST 5'd16
`define PSTDBG_IR_W 4
`define PSTDBG_IR_RESET 4'h1
`define PSTDBG_IR_IDCODE 4'h1
`define PSTDBG_IR_BYPASS 4'hf
// Identification value is arbitrary.
`define PSTDBG_IDCODE 32'h0000_0001

`endif

// [shared/pstdbg_pkg.sv]
// -----------------------------------------------------------------
// Types shared by the status and debug pin block.
// -----------------------------------------------------------------
package pstdbg_pkg;
  // Kinds of core activity reported on the status pins.
  typedef enum logic [2:0] {
    EV_INSN, EV_USER, EV_MARK, EV_BRANCH, EV_RETURN, EV_DATA, EV_EXC, EV_EMU
  } pstdbg_evt_t;

  // Status emitter states.
  typedef enum logic [1:0] {EM_RUN, EM_NIBBLE, EM_HOLD} pstdbg_em_t;

  // Test access port controller states.
  typedef enum logic [3:0] {
    T_RESET, T_IDLE, T_SEL_DR, T_CAP_DR, T_SH_DR, T_EX1_DR, T_PA_DR, T_EX2_DR,
    T_UP_DR, T_SEL_IR, T_CAP_IR, T_SH_IR, T_EX1_IR, T_PA_IR, T_EX2_IR, T_UP_IR
  } pstdbg_tap_t;
endpackage : pstdbg_pkg

// [src/pstdbg_buf.sv]
`timescale 1ns/1ps
`include "pstdbg_map.svh"

// -----------------------------------------------------------------
// Two-entry buffer; the head entry is a register driven straight out.
// -----------------------------------------------------------------
module pstdbg_buf (
  input wire logic mclk, // Block clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic inValid, // Producer offers a word.
  output logic inReady, // Buffer can take a word.
  input wire logic [`PSTDBG_EVT_W-1:0] inData, // Offered word.
  output logic outValid, // Head word is present.
  input wire logic outReady, // Consumer takes the head word.
  output logic [`PSTDBG_EVT_W-1:0] outData // Head word, from a register.
);
  import pstdbg_pkg::*;

  logic [`PSTDBG_EVT_W-1:0] second; // Word waiting behind the head.
  logic [1:0] count; // Number of words held.
  logic push; // Word enters this cycle.
  logic pop; // Word leaves this cycle.

  // Full and empty follow the count, so a stall never drops a word.
  assign inReady = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Occupancy count.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 2'd0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // Head and second slot; a new word goes wherever the queue ends.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      outData <= '0;
      second <= '0;
    end else begin
      if (pop) begin
        outData <= (count == 2'd2) ? second : inData;
      end else if (push && count == 2'd0) begin
        outData <= inData;
      end
      if (push && ((count == 2'd1 && !pop) || (count == 2'd2))) begin
        second <= inData;
      end
    end
  end
endmodule : pstdbg_buf

// [src/pstdbg_top.sv]
`timescale 1ns/1ps
`include "pstdbg_map.svh"

// -----------------------------------------------------------------
// Processor status trace pins and shared scan/debug serial pins.
// -----------------------------------------------------------------
module pstdbg_top (
  input wire logic mclk, // Processor clock, 10 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic evtValid, // Core offers an activity event.
  output logic evtReady, // Event accepted into the buffer.
  input wire pstdbg_pkg::pstdbg_evt_t evtKind, // Kind of activity.
  input wire logic [1:0] evtBytes, // Data transfer length minus one.
  input wire logic [31:0] evtData, // Data for a debug transfer.
  input wire logic coreStopped, // Core waits for an interrupt.
  input wire logic coreHalted, // Core is halted.
  output logic [3:0] statusCode, // Status pins, driven value.
  output logic statusCodeOe, // Status pins driven when high.
  output logic statusClockOut, // Status clock output.
  output logic [3:0] debugDataBus, // Debug data nibble pins.
  input wire logic debugModeSel, // Pin: high selects debug use.
  input wire logic testClock, // Pin: scan test clock.
  input wire logic debugSerialClock, // Pin: scan reset low or debug clock.
  input wire logic modeSelectIn, // Pin: mode select or breakpoint.
  input wire logic serialDataIn, // Pin: shared serial input.
  output logic serialDataOut, // Pin: shared serial output.
  output logic serialDataOutOe, // Serial output driven when high.
  output logic breakpointRequest, // One-cycle breakpoint pulse.
  output logic dbgRxValid, // One-cycle pulse: debug word received.
  output logic [16:0] dbgRxData, // Received debug word.
  input wire logic [16:0] dbgTxData // Debug word to send next.
);
  import pstdbg_pkg::*;

  // -----------------------------------------------------------------
  // Pin synchronisers.
  // -----------------------------------------------------------------
  logic [4:0] syncA; // First stage, read only by the second stage.
  logic [4:0] syncB; // Second stage, safe to use.
  logic [4:0] syncC; // Previous safe value for edge finding.
  logic debugMode; // Debug use selected.
  logic tckRise; // Test clock rising edge.
  logic tckFall; // Test clock falling edge.
  logic dsRise; // Debug clock rising edge.
  logic dsFall; // Debug clock falling edge.
  logic trstLow; // Scan reset asserted.

  // All five pins are outside the clock domain, so two stages each.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= '0;
      syncB <= '0;
      syncC <= '0;
    end else begin
      syncA <= {debugModeSel, testClock, debugSerialClock, modeSelectIn, serialDataIn};
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  assign debugMode = syncB[4];
  assign tckRise = syncB[3] && !syncC[3];
  assign tckFall = !syncB[3] && syncC[3];
  assign dsRise = syncB[2] && !syncC[2];
  assign dsFall = !syncB[2] && syncC[2];
  assign trstLow = !debugMode && !syncB[2];

  // -----------------------------------------------------------------
  // Event buffer.
  // -----------------------------------------------------------------
  logic popValid; // Buffered event present.
  logic popReady; // Emitter takes the event now.
  logic [`PSTDBG_EVT_W-1:0] popWord; // Buffered event word.
  pstdbg_evt_t popKind; // Kind of the buffered event.
  logic [1:0] popBytes; // Length of the buffered transfer.

  pstdbg_buf u_buf (
    .mclk(mclk),
    .arst_n(arst_n),
    .inValid(evtValid),
    .inReady(evtReady),
    .inData({evtKind, evtBytes, evtData}),
    .outValid(popValid),
    .outReady(popReady),
    .outData(popWord)
  );

  assign popKind = pstdbg_evt_t'(popWord[36:34]);
  assign popBytes = popWord[33:32];

  // Maps an event to its status code; reserved codes are unreachable.
  function automatic logic [3:0] codeOf(input pstdbg_evt_t k, input logic [1:0] n);
    logic [3:0] c;
    c = `PSTDBG_PST_CONTINUE;
    unique case (k)
      EV_INSN: c = `PSTDBG_PST_INSN; // R2
      EV_USER: c = `PSTDBG_PST_USER; // R2
      EV_MARK: c = `PSTDBG_PST_MARK; // R3
      EV_BRANCH: c = `PSTDBG_PST_BRANCH; // R4
      EV_RETURN: c = `PSTDBG_PST_RETURN; // R5
      EV_DATA: c = {`PSTDBG_PST_DATA, n}; // R6
      EV_EXC: c = `PSTDBG_PST_EXC; // R7
      EV_EMU: c = `PSTDBG_PST_EMU; // R7
    endcase
    return c;
  endfunction : codeOf

  // -----------------------------------------------------------------
  // Status clock and emitter.
  // -----------------------------------------------------------------
  logic tick; // Status clock is about to rise.
  pstdbg_em_t emState; // Emitter state.
  logic [1:0] holdCnt; // Remaining extra ticks of a held code.
  logic [2:0] nibCnt; // Remaining nibbles minus one.
  logic [31:0] dataShift; // Debug data still to send.

  // The status clock runs at half the processor clock; the code and the
  // clock are both flops on the same edge, so they never skew.
  assign tick = !statusClockOut;
  assign popReady = tick && emState == EM_RUN && !coreHalted && !coreStopped;

  // Status clock divider.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      statusClockOut <= 1'b0;
    end else begin
      statusClockOut <= !statusClockOut; // R16
    end
  end

  // Pins float in reset and are driven from the first edge after it.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      statusCodeOe <= 1'b0; // R1
    end else begin
      statusCodeOe <= 1'b1;
    end
  end

  // Emitter: one code per status clock period.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      emState <= EM_RUN;
      statusCode <= `PSTDBG_PST_CONTINUE;
      holdCnt <= 2'd0;
      nibCnt <= 3'd0;
      dataShift <= '0;
      debugDataBus <= 4'h0;
    end else if (tick) begin // R16
      unique case (emState)
        EM_HOLD: begin
          // Held codes stay several ticks so a sampler cannot miss them.
          if (holdCnt == 2'd0) begin
            emState <= EM_RUN;
            statusCode <= `PSTDBG_PST_CONTINUE;
          end else begin
            holdCnt <= holdCnt - 2'd1; // R9
          end
        end
        EM_NIBBLE: begin
          // Low nibble first; the code shows plain progress meanwhile.
          debugDataBus <= dataShift[3:0];
          dataShift <= {4'h0, dataShift[31:4]};
          statusCode <= `PSTDBG_PST_CONTINUE;
          if (nibCnt == 3'd0) begin
            emState <= EM_RUN;
          end else begin
            nibCnt <= nibCnt - 3'd1;
          end
        end
        EM_RUN: begin
          if (coreHalted) begin
            statusCode <= `PSTDBG_PST_HALT; // R8
          end else if (coreStopped) begin
            statusCode <= `PSTDBG_PST_STOP; // R8
          end else if (popValid) begin
            statusCode <= codeOf(popKind, popBytes); // R15
            if (popKind == EV_DATA) begin
              emState <= EM_NIBBLE; // R6
              dataShift <= popWord[31:0];
              nibCnt <= {popBytes, 1'b1};
            end else if (popKind == EV_EXC || popKind == EV_EMU) begin
              emState <= EM_HOLD; // R9
              holdCnt <= `PSTDBG_EXC_TICKS - 2'd1;
            end
          end else begin
            statusCode <= `PSTDBG_PST_CONTINUE; // R2
          end
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Boundary-scan test access port.
  // -----------------------------------------------------------------
  pstdbg_tap_t tapState; // Controller state.
  pstdbg_tap_t next_tapState; // Controller state after the edge.
  logic [`PSTDBG_IR_W-1:0] irShift; // Instruction shift stage.
  logic [`PSTDBG_IR_W-1:0] irReg; // Current instruction.
  logic [31:0] drShift; // Data shift stage.
  logic tdoBit; // Scan output, changes on the falling test clock.
  logic tdoEn; // Scan output enable.

  // Next state from mode select, as the standard controller walks.
  always_comb begin
    next_tapState = tapState;
    unique case (tapState)
      T_RESET: next_tapState = syncB[1] ? T_RESET : T_IDLE;
      T_IDLE: next_tapState = syncB[1] ? T_SEL_DR : T_IDLE;
      T_SEL_DR: next_tapState = syncB[1] ? T_SEL_IR : T_CAP_DR;
      T_CAP_DR: next_tapState = syncB[1] ? T_EX1_DR : T_SH_DR;
      T_SH_DR: next_tapState = syncB[1] ? T_EX1_DR : T_SH_DR;
      T_EX1_DR: next_tapState = syncB[1] ? T_UP_DR : T_PA_DR;
      T_PA_DR: next_tapState = syncB[1] ? T_EX2_DR : T_PA_DR;
      T_EX2_DR: next_tapState = syncB[1] ? T_UP_DR : T_SH_DR;
      T_UP_DR: next_tapState = syncB[1] ? T_SEL_DR : T_IDLE;
      T_SEL_IR: next_tapState = syncB[1] ? T_RESET : T_CAP_IR;
      T_CAP_IR: next_tapState = syncB[1] ? T_EX1_IR : T_SH_IR;
      T_SH_IR: next_tapState = syncB[1] ? T_EX1_IR : T_SH_IR;
      T_EX1_IR: next_tapState = syncB[1] ? T_UP_IR : T_PA_IR;
      T_PA_IR: next_tapState = syncB[1] ? T_EX2_IR : T_PA_IR;
      T_EX2_IR: next_tapState = syncB[1] ? T_UP_IR : T_SH_IR;
      T_UP_IR: next_tapState = syncB[1] ? T_SEL_DR : T_IDLE;
    endcase
  end

  // Controller and registers advance on the rising test clock.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tapState <= T_RESET;
      irShift <= '0;
      irReg <= `PSTDBG_IR_RESET;
      drShift <= '0;
    end else if (trstLow) begin
      tapState <= T_RESET; // R10
      irReg <= `PSTDBG_IR_RESET;
    end else if (!debugMode && tckRise) begin // R14
      tapState <= next_tapState;
      unique case (tapState)
        T_RESET: irReg <= `PSTDBG_IR_RESET;
        T_CAP_IR: irShift <= 4'h1;
        T_SH_IR: irShift <= {syncB[0], irShift[`PSTDBG_IR_W-1:1]}; // R12
        T_UP_IR: irReg <= irShift;
        T_CAP_DR: drShift <= (irReg == `PSTDBG_IR_IDCODE) ? `PSTDBG_IDCODE : 32'h0;
        T_SH_DR: begin
          // Bypass is a single stage; other instructions use the full word.
          if (irReg == `PSTDBG_IR_BYPASS) begin
            drShift <= {31'h0, syncB[0]};
          end else begin
            drShift <= {syncB[0], drShift[31:1]}; // R12
          end
        end
        default: drShift <= drShift;
      endcase
    end
  end

  // Scan output is only driven while shifting.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tdoBit <= 1'b0;
      tdoEn <= 1'b0;
    end else if (tckFall) begin
      tdoEn <= (tapState == T_SH_DR) || (tapState == T_SH_IR);
      tdoBit <= (tapState == T_SH_IR) ? irShift[0] : drShift[0];
    end
  end

  // -----------------------------------------------------------------
  // Background debug serial channel.
  // -----------------------------------------------------------------
  logic [`PSTDBG_DBG_W-1:0] dbgShift; // Debug shift stage.
  logic [4:0] dbgCnt; // Bits taken in the current word.
  logic dsoBit; // Debug output bit.
  logic bkptPrev; // Breakpoint pin seen last cycle.

  // Input taken on the rising debug clock, output moved on the falling.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dbgShift <= '0;
      dbgCnt <= 5'd0;
      dsoBit <= 1'b0;
      dbgRxValid <= 1'b0;
      dbgRxData <= '0;
    end else begin
      dbgRxValid <= 1'b0;
      if (!debugMode) begin
        dbgCnt <= 5'd0;
      end else if (dsRise) begin // R10
        if (dbgCnt == `PSTDBG_DBG_LAST) begin
          dbgRxData <= {dbgShift[15:0], syncB[0]}; // R12
          dbgRxValid <= 1'b1;
          dbgShift <= dbgTxData;
          dbgCnt <= 5'd0;
        end else begin
          dbgShift <= {dbgShift[15:0], syncB[0]};
          dbgCnt <= dbgCnt + 5'd1;
        end
      end else if (dsFall) begin
        dsoBit <= dbgShift[16];
      end
    end
  end

  // The shared pin raises a breakpoint only in debug use.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bkptPrev <= 1'b0;
      breakpointRequest <= 1'b0;
    end else begin
      bkptPrev <= syncB[1];
      breakpointRequest <= debugMode && syncB[1] && !bkptPrev; // R11
    end
  end

  // One output pin, owned by whichever function is in use.
  assign serialDataOut = debugMode ? dsoBit : tdoBit; // R13
  assign serialDataOutOe = debugMode || tdoEn; // R13

  // -----------------------------------------------------------------
  // Assertions and covers.
  // -----------------------------------------------------------------
  AST_HIZ_RESET: assert property (@(posedge mclk) !arst_n |-> !statusCodeOe) // R1
    else $error("Status pins driven during reset.");
  AST_NO_RESERVED: assert property (@(posedge mclk) disable iff (!arst_n) // R15
    statusCode != 4'h2 && statusCode != 4'h6)
    else $error("Reserved status code driven.");
  AST_INSN_CODE: assert property (@(posedge mclk) disable iff (!arst_n) // R2
    popValid && popReady && popKind == EV_INSN |=> statusCode == 4'h1)
    else $error("Instruction start not reported.");
  AST_DATA_CODE: assert property (@(posedge mclk) disable iff (!arst_n) // R6
    popValid && popReady && popKind == EV_DATA |=> statusCode == {2'b10, $past(popBytes)})
    else $error("Transfer length code wrong.");
  AST_HALT_CODE: assert property (@(posedge mclk) disable iff (!arst_n) // R8
    tick && emState == EM_RUN && coreHalted |=> statusCode == 4'hf)
    else $error("Halt not reported.");
  AST_EXC_HOLD: assert property (@(posedge mclk) disable iff (!arst_n) // R9
    $rose(statusCode == 4'hc) |-> (statusCode == 4'hc) [*4])
    else $error("Exception code too short.");
  AST_CLK_ALIGN: assert property (@(posedge mclk) disable iff (!arst_n) // R16
    $changed(statusCode) |-> $rose(statusClockOut))
    else $error("Status changed off the status clock edge.");
  AST_TAP_RESET: assert property (@(posedge mclk) disable iff (!arst_n) // R10
    trstLow |=> tapState == T_RESET)
    else $error("Scan reset ignored.");
  AST_BREAKPOINT_REQUEST_MODE: assert property (@(posedge mclk) disable iff (!arst_n) // R11
    breakpointRequest |-> $past(debugMode))
    else $error("Breakpoint outside debug use.");
  AST_DSO_OWNER: assert property (@(posedge mclk) disable iff (!arst_n) // R13
    debugMode && dsFall |=> serialDataOutOe && serialDataOut == $past(dbgShift[16]))
    else $error("Debug output not routed.");

  COV_DATA: cover property (@(posedge mclk) disable iff (!arst_n)
    statusCode == 4'hb ##2 emState == EM_NIBBLE);
  COV_EXC: cover property (@(posedge mclk) disable iff (!arst_n) $rose(statusCode == 4'hd));
  COV_HALT: cover property (@(posedge mclk) disable iff (!arst_n) statusCode == 4'hf);
  COV_SHIFT_DR: cover property (@(posedge mclk) disable iff (!arst_n) tapState == T_SH_DR);
  COV_DBG_RX: cover property (@(posedge mclk) disable iff (!arst_n) dbgRxValid);
endmodule : pstdbg_top
